// File: rtl/psr_defs.svh
// constants for the parallel/serial-in shift register
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH
`define PSR_WIDTH 8
`define PSR_CLK_NS 40
`define PSR_SYNC_DEPTH 3
`define PSR_BUF_DEPTH 2
`endif

// File: rtl/psr_pkg.sv
// types shared by the shift register design
`include "psr_defs.svh"
package psr_pkg;
   typedef logic [`PSR_WIDTH-1:0] psr_stage_t;
   typedef logic [1:0] psr_count_t;
endpackage

// File: rtl/psr_shift_reg.sv
// eight-stage shift register with parallel load, serial output and output buffer
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"

module psr_shift_reg #(
   parameter int WIDTH = `PSR_WIDTH
) (
   // system
   input wire logic clk_i,
   input wire logic rst_n_i,
   // device pins, asynchronous to clk_i
   input wire logic clear_n_i,
   input wire logic dev_clk_i,
   input wire logic inhibit_i,
   input wire logic mode_i,
   input wire logic serial_i,
   input wire logic [WIDTH-1:0] par_i,
   // serial output pin
   output logic serial_o,
   // stream of output bits, one per enabled edge
   output logic in_ready_o,
   output logic out_valid_o,
   output logic out_data_o,
   input wire logic out_ready_i
);
   import psr_pkg::*;

   localparam int NIN = WIDTH + 4;

   // bitwise agreement filter: a bit moves only when two stages agree
   function automatic logic [NIN-1:0] agree(input logic [NIN-1:0] a,
                                            input logic [NIN-1:0] b,
                                            input logic [NIN-1:0] old);
      agree = (~(a ^ b) & a) | ((a ^ b) & old);
   endfunction

   // reset release through two flops
   logic rst_q1;
   logic rst_sync_n;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q1 <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_sync_n <= rst_q1;
      end
   end

   // clear acts directly on the stages, without waiting for a clock
   // a glitch on the clear pin clears the stages too; that is accepted, not filtered
   wire arst_n = rst_sync_n & clear_n_i;

   // three-flop synchroniser on every pin except clear_n_i, first flop read only by the second
   // the third flop exists only to be compared with the second by the filter
   wire [NIN-1:0] raw = {dev_clk_i, inhibit_i, mode_i, serial_i, par_i};
   logic [NIN-1:0] s1;
   logic [NIN-1:0] s2;
   logic [NIN-1:0] s3;
   logic [NIN-1:0] filt;
   always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         filt <= agree(s2, s3, filt);
      end
   end

   // named views of the filtered pins
   wire clk_f = filt[WIDTH+3];
   wire inh_f = filt[WIDTH+2];
   wire mode_f = filt[WIDTH+1];
   wire ser_f = filt[WIDTH];
   wire [WIDTH-1:0] par_f = filt[WIDTH-1:0];

   // rising edge of the device clock; inhibit is assumed to rise only
   // while that clock is high, so gating never forges an edge
   logic clk_prev;
   always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         clk_prev <= 1'b0;
      end else begin
         clk_prev <= clk_f;
      end
   end
   wire dev_edge = clk_f & ~clk_prev;
   // inhibit is taken from its filtered copy, so it shares the data latency
   // an edge while the buffer is full is dropped; in_ready_o warns the source
   wire fire = dev_edge & ~inh_f & in_ready_o;

   // next stage contents: shift or broadside load
   // the load path never looks at ser_f, so the serial pin is ignored there
   psr_stage_t stage;
   wire [WIDTH-1:0] shifted = {stage[WIDTH-2:0], ser_f};
   wire [WIDTH-1:0] next_stage = mode_f ? shifted : par_f;

   // stage register
   always_ff @(posedge clk_i or negedge arst_n) begin
      if (!arst_n) begin
         stage <= '0;
      end else if (fire) begin
         stage <= next_stage;
      end
   end

   assign serial_o = stage[WIDTH-1];

   // two-entry buffer of output bits so a stalled receiver loses none
   // pointers wrap at two entries, so one bit each is enough
   // out_data_o selects between flops, never the live stage
   logic mem [`PSR_BUF_DEPTH];
   logic wr_ptr;
   logic rd_ptr;
   psr_count_t count;
   wire pop = out_valid_o & out_ready_i;
   assign in_ready_o = (count != 2'(`PSR_BUF_DEPTH));
   assign out_valid_o = (count != 2'h0);
   assign out_data_o = mem[rd_ptr];
   always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mem[0] <= 1'b0;
         mem[1] <= 1'b0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (fire) begin
            mem[wr_ptr] <= next_stage[WIDTH-1];
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + psr_count_t'(fire) - psr_count_t'(pop);
      end
   end

   // helper: history of serial pin bits at each accepted edge, and shifts since last load or clear
   // the count saturates so the latency check stays armed on long shift runs
   logic [WIDTH-1:0] hist;
   logic [3:0] nshift;
   always_ff @(posedge clk_i or negedge arst_n) begin
      if (!arst_n) begin
         hist <= '0;
         nshift <= 4'h0;
      end else if (fire) begin
         hist <= {hist[WIDTH-2:0], ser_f};
         if (!mode_f) begin
            nshift <= 4'h0;
         end else if (nshift != 4'hF) begin
            nshift <= nshift + 4'h1;
         end
      end
   end

   // stage checks; a clear in flight aborts those disabled on arst_n; the clear checks and edge_single_a use rst_sync_n
   hold_between_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      !fire |=> $stable(stage)) else $error("stages changed without edge");
   edge_single_a: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
      dev_edge |=> !dev_edge) else $error("one pin edge seen twice");
   shift_entry_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      fire && mode_f |=> stage[0] == $past(ser_f)) else $error("serial bit lost");
   shift_move_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      fire && mode_f |=> stage[WIDTH-1:1] == $past(stage[WIDTH-2:0]))
      else $error("shift chain broken");
   load_all_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      fire && !mode_f |=> stage == $past(par_f)) else $error("load mismatch");
   load_out_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      fire && !mode_f |=> serial_o == $past(par_f[WIDTH-1]))
      else $error("last input not on output");
   inhibit_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      dev_edge && inh_f |=> $stable(stage)) else $error("inhibit ignored");
   clear_zero_a: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
      !clear_n_i |-> stage == '0) else $error("clear did not zero stages");
   clear_out_a: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
      !clear_n_i |-> !serial_o) else $error("clear left output high");
   serial_lat_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      nshift >= 4'(WIDTH) |-> serial_o == hist[WIDTH-1])
      else $error("serial latency wrong");

   // pin filter checks: a bit moves only once the last two flops agree
   filt_take_a: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
      s2 == s3 |=> filt == $past(s2)) else $error("agreed pins not taken");
   filt_hold_a: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
      s2 != s3 |=> ((filt ^ $past(filt)) & ($past(s2) ^ $past(s3))) == '0)
      else $error("unsettled pin passed filter");

   // buffer checks: depth bound, drop when full, pushed bit is the new last stage
   buf_bound_a: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
      count <= 2'(`PSR_BUF_DEPTH)) else $error("buffer count above depth");
   full_drop_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      dev_edge && !inh_f && !in_ready_o |=> $stable(stage))
      else $error("edge taken while full");
   push_copy_a: assert property (@(posedge clk_i) disable iff (!arst_n)
      fire |=> mem[$past(wr_ptr)] == serial_o) else $error("buffered bit differs");
   pop_next_a: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
      pop && count == 2'h2 |=> out_valid_o) else $error("second entry lost");
   data_hold_a: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
      else $error("stalled bit changed");
   reset_idle_a: assert property (@(posedge clk_i)
      !rst_sync_n |-> !out_valid_o && in_ready_o) else $error("buffer busy in reset");
endmodule
`default_nettype wire

// File: sim/psr_pin_model.sv
// pin driver model for the device clock and clock inhibit
`timescale 1ns/1ps
`default_nettype none
module psr_pin_model (
   // system
   input wire logic clk_i,
   // requests from the bench
   input wire logic go_i,
   input wire logic hold_i,
   // device pins
   output logic dev_clk_o,
   output logic inhibit_o
);
   logic [3:0] cnt = 4'h0;
   initial inhibit_o = 1'b0;
   // high 7 cycles from go, then low until the next go: edges stay far apart for the pin filter
   assign dev_clk_o = cnt >= 4'h8;
   // inhibit moves only mid high phase, so no false edge appears
   always @(negedge clk_i) begin
      cnt <= go_i ? 4'hE : cnt - 4'(cnt != 4'h0);
      if (cnt == 4'hB) inhibit_o <= hold_i;
   end
endmodule
`default_nettype wire

// File: sim/psr_shift_reg_tb_top.sv
// self-checking bench for the shift register
`timescale 1ns/1ps
`default_nettype none
module psr_shift_reg_tb_top;
   logic clk_i;
   logic rst_n_i;
   logic clear_n_i;
   logic mode_i;
   logic serial_i;
   logic [7:0] par_i;
   logic go;
   logic hold;
   logic rdy;
   wire logic dev_clk, inhibit, serial_o, in_ready_o, out_valid_o, out_data_o;
   int num_errors = 0, checked = 0, cyc = 0;
   logic exp_q[$];
   always #20 clk_i = ~clk_i;
   psr_shift_reg i_psr_shift_reg (.clk_i(clk_i), .rst_n_i(rst_n_i), .clear_n_i(clear_n_i),
      .dev_clk_i(dev_clk), .inhibit_i(inhibit), .mode_i(mode_i), .serial_i(serial_i),
      .par_i(par_i), .serial_o(serial_o), .in_ready_o(in_ready_o),
      .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(rdy));
   psr_pin_model i_psr_pin_model (.clk_i(clk_i), .go_i(go), .hold_i(hold),
      .dev_clk_o(dev_clk), .inhibit_o(inhibit));
   task chk(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask
   task test_done;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one full device clock pulse; the pin filter needs the long spacing
   task pulse(input logic h, input logic m, input logic s, input logic [7:0] p);
      @(negedge clk_i);
      hold = h;
      mode_i = m;
      serial_i = s;
      par_i = p;
      // go is non-blocking: the pin model still sees the old value on this edge and reads it on the next one, without a race
      go <= 1'b1;
      @(negedge clk_i);
      go <= 1'b0;
      repeat (16) @(negedge clk_i);
   endtask
   // popped stream bits must match the last stage after each accepted edge
   always @(posedge clk_i) begin
      if (out_valid_o === 1'b1 && rdy) chk("out_data", exp_q.pop_front(), out_data_o);
   end
   // expected bits are queued before each pulse while rdy is high: the pop comes within that pulse
   task s_load_shift;
      logic e;
      exp_q.push_back(1'b1);
      pulse(0, 0, 0, 8'hA5);
      chk("load", 1'b1, serial_o);
      for (int i = 0; i < 16; i++) begin
         e = (i < 7) ? 1'(8'hA5 >> (6 - i)) : (i == 14);
         exp_q.push_back(e);
         pulse(0, 1, i == 7, 8'h00);
         chk("shift", e, serial_o);
      end
   endtask
   // inhibit raised in a high phase blocks the following edges, not the current one
   task s_inhibit;
      exp_q.push_back(1'b1);
      pulse(0, 0, 0, 8'hC0);
      exp_q.push_back(1'b1);
      pulse(1, 1, 0, 8'h00);
      pulse(1, 1, 0, 8'h00);
      chk("inhibit", 1'b1, serial_o);
      pulse(0, 1, 0, 8'h00);
      exp_q.push_back(1'b0);
      pulse(0, 1, 0, 8'h00);
      chk("resume", 1'b0, serial_o);
   endtask
   task s_clear_full;
      exp_q.push_back(1'b1);
      pulse(0, 0, 0, 8'h80);
      @(negedge clk_i);
      clear_n_i = 1'b0;
      #1 chk("clear", 1'b0, serial_o);
      @(negedge clk_i);
      clear_n_i = 1'b1;
      rdy = 1'b0;
      pulse(0, 0, 0, 8'hFF);
      pulse(0, 1, 0, 8'h00);
      chk("full", 1'b0, in_ready_o);
      pulse(0, 0, 0, 8'h00);
      chk("dropped", 1'b1, serial_o);
      exp_q.push_back(1'b1);
      exp_q.push_back(1'b1);
      rdy = 1'b1;
      repeat (4) @(negedge clk_i);
      chk("drained", 1'b0, out_valid_o);
   endtask
   // hang guard: the whole sequence needs well under 1000 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         test_done;
      end
   end
   initial begin
      clk_i = 1'b0;
      rst_n_i = 1'b0;
      clear_n_i = 1'b1;
      mode_i = 1'b0;
      serial_i = 1'b0;
      par_i = 8'h00;
      go = 1'b0;
      hold = 1'b0;
      rdy = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      s_load_shift;
      s_inhibit;
      s_clear_full;
      test_done;
   end
endmodule
`default_nettype wire
